// ### ips_pkg.sv
// constants, enums and field layouts for the port parameter and swap block
// assumes one instance per port and a 125 MHz hclk
package ips_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_MAKER  = 8'h04;
  localparam logic [7:0] OFS_PART   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_STORE  = 8'h10;

  // field positions inside the status word
  localparam int STAT_CYCLE_LSB  = 0;
  localparam int STAT_STORED_BIT = 16;
  localparam int STAT_BACKUP_BIT = 17;
  localparam int STAT_MATCH_BIT  = 18;

  typedef enum logic [1:0] {
    FAULT_CLEAR_KEEP_VALID = 2'h0,
    FAULT_HOLD             = 2'h1,
    FAULT_CLEAR_DROP_VALID = 2'h2
  } ips_fault_e;

  typedef enum logic [1:0] {
    SWAP_DIRECT = 2'h0,
    SWAP_16     = 2'h1,
    SWAP_32     = 2'h2,
    SWAP_ALL    = 2'h3
  } ips_swap_e;

  typedef enum logic [2:0] {
    VAL_NO_CHECK       = 3'h0,
    VAL_TYPE_V10       = 3'h1,
    VAL_TYPE_V11       = 3'h2,
    VAL_V11_BACKUP_RST = 3'h3,
    VAL_V11_RESTORE    = 3'h4
  } ips_valid_e;

  // control word, high bits first in the register
  typedef struct packed {
    logic [15:0] spare;
    ips_valid_e  validation;
    logic        manual_port_mode;
    ips_swap_e   swap_mode;
    logic [1:0]  fault_mode;
    logic [7:0]  port_cycle_code;
  } ips_ctrl_s;

  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [15:0] MAKER_RESET = 16'h0001;
  localparam logic [23:0] PART_RESET  = 24'h00_0001;

  // cycle times in units of 0.1 ms
  localparam logic [10:0] CYC_MIN    = 11'h004;
  localparam logic [10:0] CYC_MAX    = 11'h530;
  localparam logic [10:0] BASE1_OFS  = 11'h040;
  localparam logic [10:0] BASE2_OFS  = 11'h140;
  localparam logic [10:0] STEP0      = 11'h001;
  localparam logic [10:0] STEP1      = 11'h004;
  localparam logic [10:0] STEP2      = 11'h010;

  localparam int CLK_PERIOD_NS = 8;
  localparam int TIME_UNIT_NS  = 100000;
  localparam int TICK_CYCLES   = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // mapping area and parameter store
  localparam int MAP_BYTES   = 16;
  localparam int STORE_WORDS = 16;

endpackage

// ### ips_store_mem.sv
// small parameter store, one write port and one registered read port
// assumes the caller never reads and writes the same word in one cycle
`timescale 1ns/1ps
`default_nettype none
module ips_store_mem (
  // clock
  input  wire logic        hclk,
  // write port
  input  wire logic        wr_en,
  input  wire logic [3:0]  wr_idx,
  input  wire logic [31:0] wr_data,
  // read port
  input  wire logic        rd_en,
  input  wire logic [3:0]  rd_idx,
  output var  logic [31:0] rd_data
);

  logic [31:0] words [ips_pkg::STORE_WORDS];

  // no reset on the array; validity is tracked outside
  always_ff @(posedge hclk) begin
    if (wr_en) begin
      words[wr_idx] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= words[rd_idx];
    end
  end

endmodule // ips_store_mem
`default_nettype wire

// ### ips_port_top.sv
// one port: cycle code decode, identity compare values, fault output policy,
// process data padding and swap, parameter backup and restore store
// assumes upstream and port-engine inputs are on hclk, AHB-Lite single slave
//
// Behaviour
// - code zero uses device minimum cycle time
// - bits 5..0 multiplier, bits 7..6 time base
// - base 00 gives multiplier times 0.1 ms
// - base 01 gives 6.4 ms plus multiplier*0.4
// - base 10 gives 32 ms plus multiplier*1.6
// - clamp to 0.4 ms .. 132.8 ms
// - too fast request runs at fastest achievable
// - 16-bit nonzero maker code, reset 0x0001
// - 24-bit nonzero part code, reset 0x000001
// - clear-keep-valid zeroes outputs, valid stays high
// - hold repeats last upstream data, valid high
// - clear-drop-valid zeroes outputs, valid low
// - 16-bit swap exchanges bytes of each word
// - 32-bit swap reverses each full 4-byte padded word
// - full swap reverses whole padded area
// - short data padded with zeros, then swapped
// - two-byte area never swapped by 32-bit
// - backup only in manual with V1.1 store
// - store set, restore into replacement device
// - identity code change discards stored set
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ips_port_top #(
  parameter int TICK_CYCLES = ips_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // AHB-Lite slave
  input  wire logic         hsel,
  input  wire logic [7:0]   haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output var  logic [31:0]  hrdata,
  output var  logic         hreadyout,
  output var  logic         hresp,
  // upstream process image
  input  wire logic         upstream_fault,
  input  wire logic         out_image_strobe,
  input  wire logic [127:0] out_image,
  // port engine: timing and identity
  input  wire logic [10:0]  dev_min_cycle,
  input  wire logic [10:0]  port_fastest_cycle,
  input  wire logic [15:0]  actual_maker_code,
  input  wire logic [23:0]  actual_part_code,
  // port engine: process data from device
  input  wire logic         dev_pd_strobe,
  input  wire logic [127:0] dev_pd,
  input  wire logic [4:0]   dev_pd_len,
  input  wire logic [4:0]   map_len,
  // port engine: parameter upload and download
  input  wire logic         param_wr_valid,
  input  wire logic [3:0]   param_wr_idx,
  input  wire logic [31:0]  param_wr_data,
  input  wire logic         param_wr_commit,
  input  wire logic         param_rd_req,
  input  wire logic [3:0]   param_rd_idx,
  // outputs to port engine
  output var  logic [127:0] port_out_data,
  output var  logic         port_out_valid,
  output var  logic [127:0] mapped_pd,
  output var  logic [10:0]  cycle_time,
  output var  logic         cycle_start,
  output var  logic         id_mismatch,
  output var  logic         backup_enable,
  output var  logic         restore_enable,
  output var  logic [31:0]  param_rd_data,
  output var  logic         param_rd_valid
);

  ips_pkg::ips_ctrl_s ctrl;
  logic [15:0] expected_maker_code;
  logic [23:0] expected_part_code;
  logic        stored_valid;

  // AHB address phase capture
  logic       dp_write;
  logic [7:0] dp_addr;
  wire        ahb_take  = hsel & htrans[1] & hready;
  wire        ahb_wr    = dp_write;
  wire        wr_ctrl   = ahb_wr & (dp_addr == ips_pkg::OFS_CTRL);
  wire        wr_maker  = ahb_wr & (dp_addr == ips_pkg::OFS_MAKER);
  wire        wr_part   = ahb_wr & (dp_addr == ips_pkg::OFS_PART);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      dp_write  <= ahb_take & hwrite;
      dp_addr   <= haddr;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // zero-valued identity writes are dropped, the field only holds nonzero codes
  wire [15:0] maker_wval  = hwdata[15:0];
  wire [23:0] part_wval   = hwdata[23:0];
  wire        maker_load  = wr_maker & (maker_wval != 16'h0000);
  wire        part_load   = wr_part & (part_wval != 24'h00_0000);
  wire        id_changed  = (maker_load & (maker_wval != expected_maker_code)) |
                            (part_load & (part_wval != expected_part_code));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl                <= ips_pkg::CTRL_RESET;
      expected_maker_code <= ips_pkg::MAKER_RESET;
      expected_part_code  <= ips_pkg::PART_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= hwdata;
      end
      if (maker_load) begin
        expected_maker_code <= maker_wval;
      end
      if (part_load) begin
        expected_part_code <= part_wval;
      end
    end
  end

  // cycle code decode, all in 0.1 ms units
  wire [1:0]  time_base  = ctrl.port_cycle_code[7:6];
  wire [10:0] multiplier = {5'h00, ctrl.port_cycle_code[5:0]};
  wire [10:0] cyc_base0  = multiplier * ips_pkg::STEP0;
  wire [10:0] cyc_base1  = ips_pkg::BASE1_OFS + multiplier * ips_pkg::STEP1;
  wire [10:0] cyc_base2  = ips_pkg::BASE2_OFS + multiplier * ips_pkg::STEP2;
  wire [10:0] cyc_raw    = (time_base == 2'b00) ? cyc_base0 :
                           (time_base == 2'b01) ? cyc_base1 :
                           (time_base == 2'b10) ? cyc_base2 : ips_pkg::CYC_MAX;
  wire [10:0] cyc_sel    = (ctrl.port_cycle_code == 8'h00) ? dev_min_cycle : cyc_raw;
  wire [10:0] cyc_req    = (cyc_sel < ips_pkg::CYC_MIN) ? ips_pkg::CYC_MIN :
                           (cyc_sel > ips_pkg::CYC_MAX) ? ips_pkg::CYC_MAX : cyc_sel;
  // the port engine knows what it can sustain; never run faster than that
  wire [10:0] next_cycle_time = (cyc_req < port_fastest_cycle) ? port_fastest_cycle
                                                               : cyc_req;

  // cycle pacing: 0.1 ms ticks counted up to the effective cycle time
  logic [15:0] tick_cnt;
  logic [10:0] unit_cnt;
  wire         tick_end = (tick_cnt == 16'(TICK_CYCLES - 1));
  wire         unit_end = (unit_cnt >= cycle_time - 11'h001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cycle_time  <= ips_pkg::CYC_MIN;
      tick_cnt    <= 16'h0000;
      unit_cnt    <= 11'h000;
      cycle_start <= 1'b0;
    end else begin
      cycle_time  <= next_cycle_time;
      tick_cnt    <= tick_end ? 16'h0000 : tick_cnt + 16'h0001;
      cycle_start <= tick_end & unit_end;
      if (tick_end) begin
        unit_cnt <= unit_end ? 11'h000 : unit_cnt + 11'h001;
      end
    end
  end

  // identity compare only matters once checking is on
  wire check_on  = (ctrl.validation != ips_pkg::VAL_NO_CHECK);
  wire id_equal  = (actual_maker_code == expected_maker_code) &
                   (actual_part_code == expected_part_code);
  wire next_mism = check_on & ~id_equal;

  // output policy while upstream is faulted
  logic [127:0] last_out;
  wire          fault_keep  = (ctrl.fault_mode == ips_pkg::FAULT_CLEAR_KEEP_VALID);
  wire          fault_hold  = (ctrl.fault_mode == ips_pkg::FAULT_HOLD);
  wire [127:0]  next_out    = !upstream_fault ? last_out :
                              fault_hold      ? last_out : 128'h0;
  wire          next_ovalid = !upstream_fault | fault_keep | fault_hold;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_out       <= 128'h0;
      port_out_data  <= 128'h0;
      port_out_valid <= 1'b0;
      id_mismatch    <= 1'b0;
    end else begin
      // fresh upstream data is ignored while faulted so hold keeps the last good set
      if (out_image_strobe & !upstream_fault) begin
        last_out <= out_image;
      end
      port_out_data  <= next_out;
      port_out_valid <= next_ovalid;
      id_mismatch    <= next_mism;
    end
  end

  // padding and swap of device process data into the mapping area
  logic [7:0] pad_byte [ips_pkg::MAP_BYTES];
  logic [7:0] swp_byte [ips_pkg::MAP_BYTES];
  wire        map_is_two = (map_len == 5'h02);

  for (genvar j = 0; j < ips_pkg::MAP_BYTES; j++) begin : g_map
    localparam logic [4:0] J = 5'(j);
    wire        in_map  = (J < map_len);
    wire        in_data = (J < dev_pd_len) & in_map;
    wire        word_in = ((J | 5'h03) < map_len);
    wire [4:0]  src16   = J ^ 5'h01;
    wire [4:0]  src32   = (map_is_two | !word_in) ? J : (J ^ 5'h03);
    wire [4:0]  srcall  = map_len - 5'h01 - J;
    wire [4:0]  src     = (ctrl.swap_mode == ips_pkg::SWAP_16)  ? src16 :
                          (ctrl.swap_mode == ips_pkg::SWAP_32)  ? src32 :
                          (ctrl.swap_mode == ips_pkg::SWAP_ALL) ? srcall : J;
    assign pad_byte[j] = in_data ? dev_pd[8*j +: 8] : 8'h00;
    // swap reads the padded bytes, so zeros move with the data
    assign swp_byte[j] = in_map ? pad_byte[src[3:0]] : 8'h00;
  end

  logic [127:0] next_mapped;
  always_comb begin
    next_mapped = 128'h0;
    for (int k = 0; k < ips_pkg::MAP_BYTES; k++) begin
      next_mapped[8*k +: 8] = swp_byte[k];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mapped_pd <= 128'h0;
    end else if (dev_pd_strobe) begin
      mapped_pd <= next_mapped;
    end
  end

  // parameter store enable and validity
  wire v11_store   = (ctrl.validation == ips_pkg::VAL_V11_BACKUP_RST) |
                     (ctrl.validation == ips_pkg::VAL_V11_RESTORE);
  wire store_on    = ctrl.manual_port_mode & v11_store;
  wire backup_ok   = ctrl.manual_port_mode &
                     (ctrl.validation == ips_pkg::VAL_V11_BACKUP_RST);
  wire store_set   = backup_ok & param_wr_commit;
  wire store_clear = id_changed | !store_on;
  wire mem_wr      = backup_ok & param_wr_valid;
  wire mem_rd      = store_on & stored_valid & param_rd_req;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stored_valid   <= 1'b0;
      backup_enable  <= 1'b0;
      restore_enable <= 1'b0;
      param_rd_valid <= 1'b0;
    end else begin
      // a commit in the same cycle as a clear keeps the fresh set
      if (store_set) begin
        stored_valid <= 1'b1;
      end else if (store_clear) begin
        stored_valid <= 1'b0;
      end
      backup_enable  <= backup_ok;
      restore_enable <= store_on & stored_valid;
      param_rd_valid <= mem_rd;
    end
  end

  ips_store_mem u_store (
    .hclk    (hclk),
    .wr_en   (mem_wr),
    .wr_idx  (param_wr_idx),
    .wr_data (param_wr_data),
    .rd_en   (mem_rd),
    .rd_idx  (param_rd_idx),
    .rd_data (param_rd_data)
  );

  // register read mux, returned in the data phase from a flop
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ips_pkg::STAT_CYCLE_LSB +: 11] = cycle_time;
    status_word[ips_pkg::STAT_STORED_BIT]      = stored_valid;
    status_word[ips_pkg::STAT_BACKUP_BIT]      = backup_enable;
    status_word[ips_pkg::STAT_MATCH_BIT]       = ~id_mismatch;
  end

  wire [31:0] rd_mux = (haddr == ips_pkg::OFS_CTRL)   ? ctrl :
                       (haddr == ips_pkg::OFS_MAKER)  ? {16'h0000, expected_maker_code} :
                       (haddr == ips_pkg::OFS_PART)   ? {8'h00, expected_part_code} :
                       (haddr == ips_pkg::OFS_STATUS) ? status_word :
                       (haddr == ips_pkg::OFS_STORE)  ? {31'h0000_0000, stored_valid} :
                                                        32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ahb_take & !hwrite) begin
      hrdata <= rd_mux;
    end
  end

endmodule // ips_port_top
`default_nettype wire

// ### ips_port_checker.sv
// pin-level assertions for the port parameter and swap block
// assumes it is bound into ips_port_top, single hclk domain
`timescale 1ns/1ps
`default_nettype none
module ips_port_checker (
  // clock and reset
  input wire logic         hclk,
  input wire logic         hresetn,
  // watched pins
  input wire logic         hreadyout,
  input wire logic         hresp,
  input wire logic         upstream_fault,
  input wire logic [127:0] port_out_data,
  input wire logic         port_out_valid,
  input wire logic         dev_pd_strobe,
  input wire logic [4:0]   dev_pd_len,
  input wire logic [127:0] mapped_pd,
  input wire logic [10:0]  port_fastest_cycle,
  input wire logic [10:0]  cycle_time,
  input wire logic         cycle_start,
  input wire logic         param_rd_req,
  input wire logic         param_rd_valid
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_zero_wait; $past(hresetn) |-> hreadyout && !hresp; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("bus stalled or errored");
  property p_invalid_zero; !port_out_valid |-> port_out_data == '0; endproperty
  a_invalid_zero: assert property (p_invalid_zero) else $error("invalid output not zero");
  property p_run_valid; !upstream_fault |=> port_out_valid; endproperty
  a_run_valid: assert property (p_run_valid) else $error("output valid dropped");
  // mode is never rewritten while the link is down
  property p_fault_still; upstream_fault [*2] |=> $stable(port_out_data); endproperty
  a_fault_still: assert property (p_fault_still) else $error("output moved in fault");
  property p_clamp;
    cycle_time >= ips_pkg::CYC_MIN && cycle_time <= ips_pkg::CYC_MAX;
  endproperty
  a_clamp: assert property (p_clamp) else $error("cycle time out of range");
  property p_fastest; 1 |=> cycle_time >= $past(port_fastest_cycle); endproperty
  a_fastest: assert property (p_fastest) else $error("cycle faster than port");
  property p_pad_empty; dev_pd_strobe && dev_pd_len == 5'h00 |=> mapped_pd == '0; endproperty
  a_pad_empty: assert property (p_pad_empty) else $error("empty data not padded");
  property p_map_hold; !dev_pd_strobe |=> $stable(mapped_pd); endproperty
  a_map_hold: assert property (p_map_hold) else $error("mapped data moved");
  property p_rd_cause; param_rd_valid |-> $past(param_rd_req); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("stray parameter answer");
  property p_start_pulse; cycle_start |=> !cycle_start [*3]; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("cycle start too wide");
endmodule // ips_port_checker
`default_nettype wire

// ### ips_dev_model.sv
// behavioural field device behind the port engine
// assumes the bench calls its tasks right after a rising hclk edge
`timescale 1ns/1ps
`default_nettype none
module ips_dev_model (
  // clock
  input  wire logic         hclk,
  // timing and identity
  output var  logic [10:0]  dev_min_cycle,
  output var  logic [10:0]  port_fastest_cycle,
  output var  logic [15:0]  actual_maker_code,
  output var  logic [23:0]  actual_part_code,
  // process data
  output var  logic         dev_pd_strobe,
  output var  logic [127:0] dev_pd,
  output var  logic [4:0]   dev_pd_len,
  output var  logic [4:0]   map_len,
  // parameter set
  output var  logic         param_wr_valid,
  output var  logic [3:0]   param_wr_idx,
  output var  logic [31:0]  param_wr_data,
  output var  logic         param_wr_commit,
  output var  logic         param_rd_req,
  output var  logic [3:0]   param_rd_idx,
  input  wire logic [31:0]  param_rd_data,
  input  wire logic         param_rd_valid
);
  initial begin
    dev_min_cycle = 11'h019;
    port_fastest_cycle = 11'h000;
    actual_maker_code = 16'h0001;
    actual_part_code = 24'h00_0001;
    {dev_pd_strobe, dev_pd, dev_pd_len, map_len} = '0;
    {param_wr_valid, param_wr_idx, param_wr_data, param_wr_commit} = '0;
    {param_rd_req, param_rd_idx} = '0;
  end
  task automatic set_fast(input logic [10:0] t);
    port_fastest_cycle <= t;
  endtask
  task automatic send_pd(input logic [127:0] d, input logic [4:0] n, a);
    @(posedge hclk);
    dev_pd <= d;
    dev_pd_len <= n;
    map_len <= a;
    dev_pd_strobe <= 1'b1;
    @(posedge hclk);
    dev_pd_strobe <= 1'b0;
    // released lines never keep the last value
    dev_pd <= ~d;
  endtask
  task automatic upload(input logic [31:0] w0, w1);
    @(posedge hclk);
    {param_wr_valid, param_wr_idx, param_wr_data} <= {1'b1, 4'h0, w0};
    @(posedge hclk);
    {param_wr_idx, param_wr_data} <= {4'h1, w1};
    @(posedge hclk);
    {param_wr_valid, param_wr_commit, param_wr_data} <= {1'b0, 1'b1, ~w1};
    @(posedge hclk);
    param_wr_commit <= 1'b0;
  endtask
  task automatic fetch(input logic [3:0] idx, output logic [31:0] d, output logic ok);
    ok = 1'b0;
    d = '0;
    @(posedge hclk);
    {param_rd_req, param_rd_idx} <= {1'b1, idx};
    @(posedge hclk);
    {param_rd_req, param_rd_idx} <= {1'b0, ~idx};
    repeat (8) begin
      @(posedge hclk);
      if (!ok && param_rd_valid === 1'b1) begin
        ok = 1'b1;
        d = param_rd_data;
      end
    end
  endtask
endmodule // ips_dev_model
`default_nettype wire

// ### iolink_port_param_swap_tb.sv
// self-checking bench: bus master, upstream image and a field device model
// assumes ips_pkg, design, checker and model compiled first
`timescale 1ns/1ps
`default_nettype none
module iolink_port_param_swap_tb;
  localparam logic [7:0] CORNER [11] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h3f, 8'h40,
                                         8'h7f, 8'h80, 8'hbf, 8'hc0, 8'hff};
  localparam logic [4:0] LENS [4] = '{5'h08, 5'h0a, 5'h02, 5'h00};
  localparam logic [4:0] AREA [4] = '{5'h08, 5'h10, 5'h02, 5'h06};
  logic         hclk, hresetn, hsel, hwrite, upstream_fault, out_image_strobe, ok;
  logic [7:0]   haddr, c;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  hwdata, hrdata, param_wr_data, param_rd_data, seed, rd;
  logic         hreadyout, hresp, dev_pd_strobe, param_wr_valid, param_wr_commit;
  logic         param_rd_req, param_rd_valid, port_out_valid, cycle_start, id_mismatch;
  logic         backup_enable, restore_enable;
  logic [127:0] out_image, dev_pd, port_out_data, mapped_pd, img;
  logic [10:0]  dev_min_cycle, port_fastest_cycle, cycle_time;
  logic [15:0]  actual_maker_code;
  logic [23:0]  actual_part_code;
  logic [4:0]   dev_pd_len, map_len;
  logic [3:0]   param_wr_idx, param_rd_idx;
  int           miscompares = 0, checked = 0;

  ips_port_top #(.TICK_CYCLES(4)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .upstream_fault(upstream_fault), .out_image_strobe(out_image_strobe),
    .out_image(out_image), .dev_min_cycle(dev_min_cycle),
    .port_fastest_cycle(port_fastest_cycle), .actual_maker_code(actual_maker_code),
    .actual_part_code(actual_part_code), .dev_pd_strobe(dev_pd_strobe), .dev_pd(dev_pd),
    .dev_pd_len(dev_pd_len), .map_len(map_len), .param_wr_valid(param_wr_valid),
    .param_wr_idx(param_wr_idx), .param_wr_data(param_wr_data),
    .param_wr_commit(param_wr_commit), .param_rd_req(param_rd_req),
    .param_rd_idx(param_rd_idx), .port_out_data(port_out_data),
    .port_out_valid(port_out_valid), .mapped_pd(mapped_pd), .cycle_time(cycle_time),
    .cycle_start(cycle_start), .id_mismatch(id_mismatch), .backup_enable(backup_enable),
    .restore_enable(restore_enable), .param_rd_data(param_rd_data),
    .param_rd_valid(param_rd_valid));
  ips_dev_model u_dev (.hclk(hclk), .dev_min_cycle(dev_min_cycle),
    .port_fastest_cycle(port_fastest_cycle), .actual_maker_code(actual_maker_code),
    .actual_part_code(actual_part_code), .dev_pd_strobe(dev_pd_strobe), .dev_pd(dev_pd),
    .dev_pd_len(dev_pd_len), .map_len(map_len), .param_wr_valid(param_wr_valid),
    .param_wr_idx(param_wr_idx), .param_wr_data(param_wr_data),
    .param_wr_commit(param_wr_commit), .param_rd_req(param_rd_req),
    .param_rd_idx(param_rd_idx), .param_rd_data(param_rd_data),
    .param_rd_valid(param_rd_valid));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] ctl(input logic [7:0] cc, input logic [1:0] f, s,
                                      input logic m, input logic [2:0] v);
    return {16'h0000, v, m, s, f, cc};
  endfunction
  function automatic logic [10:0] exp_cyc(input logic [7:0] cc, input logic [10:0] fast);
    logic [10:0] t;
    logic [10:0] m;
    m = {5'h00, cc[5:0]};
    case (cc[7:6])
      2'h0: t = m;
      2'h1: t = 11'h040 + 11'h004 * m;
      2'h2: t = 11'h140 + 11'h010 * m;
      default: t = 11'h530;
    endcase
    if (cc == 8'h00) t = dev_min_cycle;
    if (t < 11'h004) t = 11'h004;
    return (t < fast) ? fast : t;
  endfunction
  function automatic logic [127:0] exp_sw(input logic [127:0] d, input int n, a, md);
    logic [127:0] r;
    int s;
    r = '0;
    for (int j = 0; j < a; j++) begin
      s = (md == 1) ? j ^ 1 : (md == 2 && a != 2 && (j | 3) < a) ? j ^ 3 : j;
      if (md == 3) s = a - 1 - j;
      r[8*j+:8] = (s < n) ? d[8*s+:8] : 8'h00;
    end
    return r;
  endfunction

  task automatic chk(input string nm, input logic [127:0] got, exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    if (miscompares == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      final_report();
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    {hsel, haddr, hwrite, htrans} <= {1'b1, a, w, 2'h2};
    wait_rdy();
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic new_img();
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      img[32*k+:32] = seed;
    end
  endtask
  task automatic drive_img(input logic [127:0] d);
    @(posedge hclk);
    {out_image, out_image_strobe} <= {d, 1'b1};
    @(posedge hclk);
    out_image_strobe <= 1'b0;
  endtask

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, upstream_fault} = '0;
    {out_image_strobe, out_image, img} = '0;
    hsize = 3'h2;
    seed = 32'h6154_6f8d;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, ips_pkg::OFS_CTRL, 32'h0000_0000);
    chk("ctrl", rd, 32'h0000_0000);
    ahb(1'b1, ips_pkg::OFS_MAKER, 32'h0000_0000);
    ahb(1'b0, ips_pkg::OFS_MAKER, 32'h0000_0000);
    chk("maker", rd, 32'h0000_0001);
    ahb(1'b1, ips_pkg::OFS_PART, 32'h0000_0000);
    ahb(1'b0, ips_pkg::OFS_PART, 32'h0000_0000);
    chk("part", rd, 32'h0000_0001);
    ahb(1'b0, 8'h14, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      c = (i < 11) ? CORNER[i] : seed[7:0];
      ahb(1'b1, ips_pkg::OFS_CTRL, ctl(c, 2'h0, 2'h0, 1'b0, 3'h0));
      repeat (2) @(posedge hclk);
      chk("cycle_time", cycle_time, exp_cyc(c, 11'h000));
    end
    u_dev.set_fast(11'h0c8);
    ahb(1'b1, ips_pkg::OFS_CTRL, ctl(8'h05, 2'h0, 2'h0, 1'b0, 3'h0));
    @(posedge hclk);
    ahb(1'b0, ips_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status_cycle", rd[10:0], 11'h0c8);
    u_dev.set_fast(11'h000);
    for (int i = 0; i < 16; i++) begin
      new_img();
      ahb(1'b1, ips_pkg::OFS_CTRL, ctl(8'h04, 2'h0, i[1:0], 1'b0, 3'h0));
      u_dev.send_pd(img, LENS[i/4], AREA[i/4]);
      @(posedge hclk);
      chk("mapped_pd", mapped_pd, exp_sw(img, LENS[i/4], AREA[i/4], i%4));
    end
    for (int f = 0; f < 3; f++) begin
      ahb(1'b1, ips_pkg::OFS_CTRL, ctl(8'h04, f[1:0], 2'h0, 1'b0, 3'h0));
      new_img();
      drive_img(img);
      repeat (2) @(posedge hclk);
      chk("port_out_data", port_out_data, img);
      upstream_fault <= 1'b1;
      drive_img(~img);
      repeat (2) @(posedge hclk);
      chk("port_out_data", port_out_data, (f == 1) ? img : 128'h0);
      chk("port_out_valid", port_out_valid, f != 2);
      upstream_fault <= 1'b0;
      @(posedge hclk);
    end
    for (int i = 0; i < 2; i++) begin
      ahb(1'b1, ips_pkg::OFS_CTRL, ctl(8'h04, 2'h0, 2'h0, 1'b1, 3'h3));
      u_dev.upload(32'h1357_9bdf, seed);
      ahb(1'b0, ips_pkg::OFS_STATUS, 32'h0000_0000);
      chk("stored", rd[ips_pkg::STAT_STORED_BIT], 1'b1);
      chk("enables", {backup_enable, restore_enable}, 2'b11);
      u_dev.fetch(4'h1, rd, ok);
      chk("restore_word", {ok, rd}, {1'b1, seed});
      ahb(1'b1, i ? ips_pkg::OFS_PART : ips_pkg::OFS_MAKER, 32'h0000_1234);
      ahb(1'b0, ips_pkg::OFS_STATUS, 32'h0000_0000);
      chk("stored", rd[ips_pkg::STAT_STORED_BIT], 1'b0);
      chk("id_mismatch", id_mismatch, 1'b1);
    end
    ahb(1'b1, ips_pkg::OFS_CTRL, ctl(8'h04, 2'h0, 2'h0, 1'b1, 3'h2));
    repeat (2) @(posedge hclk);
    chk("enables", {backup_enable, restore_enable}, 2'b00);
    final_report();
  end
endmodule // iolink_port_param_swap_tb

bind ips_port_top ips_port_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .upstream_fault(upstream_fault),
  .port_out_data(port_out_data), .port_out_valid(port_out_valid),
  .dev_pd_strobe(dev_pd_strobe), .dev_pd_len(dev_pd_len), .mapped_pd(mapped_pd),
  .port_fastest_cycle(port_fastest_cycle), .cycle_time(cycle_time),
  .cycle_start(cycle_start), .param_rd_req(param_rd_req),
  .param_rd_valid(param_rd_valid));
`default_nettype wire
